/* hw/piu_pkg.sv */
package piu_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int PIU_CHANNELS   = 4;
  localparam int PIU_NODES      = 4;
  localparam int PIU_MSG_W      = 8;
  localparam int PIU_SYN_W      = 2;
  localparam int PIU_ID_W       = 3;
  localparam int PIU_FIFO_DEPTH = 8;
  localparam int PIU_LONG_TICKS = 4;
  localparam int PIU_CNT_W      = 3;
  // ----------------------------------------------------------------
  // Field positions of a timing-pulse pair
  // ----------------------------------------------------------------
  localparam int PIU_PULSE_SHORT = 0;
  localparam int PIU_PULSE_LONG  = 1;
  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PIU_MODE_STROBED = 2'h0,
    PIU_MODE_BUFFERED = 2'h1,
    PIU_MODE_PE_COMM = 2'h2,
    PIU_MODE_SYNC = 2'h3
  } piu_mode_t;
  typedef enum logic {
    PIU_KIND_PE  = 1'h0,
    PIU_KIND_ACK = 1'h1
  } piu_kind_t;
  typedef enum logic [2:0] {
    PIU_ST_IDLE  = 3'h1,
    PIU_ST_LISTEN = 3'h2,
    PIU_ST_DRAIN = 3'h4
  } piu_state_t;
endpackage

/* hw/piu_link_if.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Link between input unit and its consumers
// ------------------------------------------------------------------
interface piu_link_if
  import piu_pkg::*;
#(
  parameter int CH   = PIU_CHANNELS,
  parameter int MW   = PIU_MSG_W,
  parameter int IDW  = PIU_ID_W
);
  logic                vote_result_valid;
  logic                vote_result_final;
  logic                diag_result_valid;
  logic [CH-1:0]       diag_channel_bad;
  logic [CH-1:0][1:0]  rx_init_pulses;
  logic [CH-1:0][1:0]  rx_echo_pulses;
  logic [CH-1:0][MW-1:0] rx_msg_content;
  logic [CH-1:0]       rx_msg_strobe;
  logic                inunit_done;
  logic                inunit_listening;
  piu_kind_t           msg_kind_tag;
  logic [IDW-1:0]      msg_origin_node;
  logic                sink_ready;

  modport unit (
    input  vote_result_valid, vote_result_final, diag_result_valid, diag_channel_bad,
    input  sink_ready,
    output rx_init_pulses, rx_echo_pulses, rx_msg_content, rx_msg_strobe,
    output inunit_done, inunit_listening, msg_kind_tag, msg_origin_node
  );
  modport pipe (
    output vote_result_valid, vote_result_final, diag_result_valid, diag_channel_bad,
    output sink_ready,
    input  rx_init_pulses, rx_echo_pulses, rx_msg_content, rx_msg_strobe,
    input  inunit_done, inunit_listening, msg_kind_tag, msg_origin_node
  );
endinterface

/* hw/piu_fifo.sv */
`timescale 1ns/1ps
module piu_fifo
#(
  parameter int W = 8,
  parameter int D = 8
)
(
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } piu_fifo_st_t;
  piu_fifo_st_t  s_q;
  piu_fifo_st_t  s_d;
  logic [W-1:0]  mem [D];
  logic          push;
  logic          pop;

  assign o_in_ready  = (s_q.cnt != (AW+1)'(D));
  assign o_out_valid = (s_q.cnt != '0);
  assign o_out_data  = mem[s_q.rd];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.wr = (s_q.wr == AW'(D-1)) ? '0 : s_q.wr + 1'b1;
    end
    if (pop)
    begin
      s_d.rd = (s_q.rd == AW'(D-1)) ? '0 : s_q.rd + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Storage needs no reset; only the count defines validity
  always_ff @(posedge i_sys_clk)
  begin
    if (push)
    begin
      mem[s_q.wr] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

/* hw/piu_unit.sv */
`timescale 1ns/1ps
// Summary of operation
// - Voter flags each new result valid
// - Voter marks final result while valid
// - Diagnosis gives one bad bit per channel
// - Diagnosis flags each new result valid
// - Per-channel INIT short and long pulses
// - Per-channel ECHO short and long pulses
// - Sync pulses matter only during sync
// - Content valid with strobe or done flag
// - Output strobe one tick after input strobe
// - Done flag on activity end, low at reset
// - Listening flag while messages expected
// - Tag PE or acknowledge while done high
// - Origin node one to N on dequeue done, zero until first dequeue
// - Capture content and syndrome on strobe
module piu_unit
  import piu_pkg::*;
#(
  parameter int CH    = PIU_CHANNELS,
  parameter int NODES = PIU_NODES,
  parameter int MW    = PIU_MSG_W,
  parameter int SW    = PIU_SYN_W,
  parameter int IDW   = PIU_ID_W
)
(
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_minor_reset,
  input  wire piu_mode_t             i_rx_mode,
  input  wire logic                  i_window_open,
  input  wire logic [CH-1:0]         i_link_strobe_in,
  input  wire logic [CH-1:0][MW-1:0] i_receiver_content,
  input  wire logic [CH-1:0][SW-1:0] i_receiver_syndrome,
  input  wire logic [CH-1:0]         i_accept_init,
  input  wire logic [CH-1:0]         i_accept_echo,
  output logic [CH-1:0][SW-1:0]      o_syndrome,
  output logic                       o_vote_final,
  output logic [CH-1:0]              o_diag_bad,
  piu_link_if.unit                   lnk
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int FW = MW + SW + IDW;
  typedef struct packed {
    piu_state_t                  st;
    logic [CH-1:0]               strobe;
    logic [CH-1:0][MW-1:0]       content;
    logic [CH-1:0][SW-1:0]       syn;
    logic [CH-1:0][1:0]          init_p;
    logic [CH-1:0][1:0]          echo_p;
    logic [CH-1:0][PIU_CNT_W-1:0] init_cnt;
    logic [CH-1:0][PIU_CNT_W-1:0] echo_cnt;
    logic                        done;
    logic                        listening;
    piu_kind_t                   kind;
    logic [IDW-1:0]              origin;
    logic                        vfinal;
    logic [CH-1:0]               dbad;
  } piu_unit_st_t;
  piu_unit_st_t s_q;
  piu_unit_st_t s_d;

  // Buffered path: first channel with a strobe is queued per tick
  logic           f_in_valid;
  logic [FW-1:0]  f_in_data;
  logic           f_out_valid;
  logic           f_out_ready;
  logic [FW-1:0]  f_out_data;
  logic [IDW-1:0] pick_id;
  logic [MW-1:0]  pick_msg;
  logic [SW-1:0]  pick_syn;

  always_comb
  begin
    f_in_valid = 1'b0;
    pick_id    = '0;
    pick_msg   = '0;
    pick_syn   = '0;
    for (int c = CH - 1; c >= 0; c--)
    begin
      if (i_link_strobe_in[c])
      begin
        f_in_valid = (i_rx_mode == PIU_MODE_BUFFERED) || (i_rx_mode == PIU_MODE_PE_COMM);
        pick_id    = IDW'(c + 1);
        pick_msg   = i_receiver_content[c];
        pick_syn   = i_receiver_syndrome[c];
      end
    end
  end
  assign f_in_data   = {pick_id, pick_syn, pick_msg};
  // One entry leaves per done pulse; a stalled sink leaves it queued
  assign f_out_ready = lnk.sink_ready && !s_q.done && (s_q.st != PIU_ST_IDLE);

  piu_fifo #(
    .W (FW),
    .D (PIU_FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (f_in_valid),
    .o_in_ready  (),
    .i_in_data   (f_in_data),
    .o_out_valid (f_out_valid),
    .i_out_ready (f_out_ready),
    .o_out_data  (f_out_data)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d        = s_q;
    s_d.done   = 1'b0;
    s_d.vfinal = lnk.vote_result_valid && lnk.vote_result_final;
    if (lnk.diag_result_valid)
    begin
      s_d.dbad = lnk.diag_channel_bad;
    end
    s_d.strobe = i_minor_reset ? '0 : i_link_strobe_in;
    for (int c = 0; c < CH; c++)
    begin
      if (i_link_strobe_in[c])
      begin
        s_d.content[c] = i_receiver_content[c];
        s_d.syn[c]     = i_receiver_syndrome[c];
      end
      // Short pulse lasts one tick; long pulse a fixed count
      s_d.init_p[c][PIU_PULSE_SHORT] = i_accept_init[c];
      s_d.echo_p[c][PIU_PULSE_SHORT] = i_accept_echo[c];
      if (i_accept_init[c])
      begin
        s_d.init_cnt[c] = PIU_CNT_W'(PIU_LONG_TICKS);
      end
      else if (s_q.init_cnt[c] != '0)
      begin
        s_d.init_cnt[c] = s_q.init_cnt[c] - 1'b1;
      end
      if (i_accept_echo[c])
      begin
        s_d.echo_cnt[c] = PIU_CNT_W'(PIU_LONG_TICKS);
      end
      else if (s_q.echo_cnt[c] != '0)
      begin
        s_d.echo_cnt[c] = s_q.echo_cnt[c] - 1'b1;
      end
      // Outside sync mode these are don't-care, left running for simplicity
      s_d.init_p[c][PIU_PULSE_LONG] = (s_d.init_cnt[c] != '0);
      s_d.echo_p[c][PIU_PULSE_LONG] = (s_d.echo_cnt[c] != '0);
    end
    case (s_q.st)
      PIU_ST_IDLE:
      begin
        if (i_window_open)
        begin
          s_d.st        = PIU_ST_LISTEN;
          s_d.listening = 1'b1;
        end
      end
      PIU_ST_LISTEN:
      begin
        if (f_out_valid && f_out_ready)
        begin
          s_d.done    = 1'b1;
          s_d.content[0] = f_out_data[MW-1:0];
          s_d.origin  = f_out_data[FW-1 -: IDW];
          s_d.kind    = (f_out_data[MW+SW-1 -: SW] != '0) ? PIU_KIND_ACK : PIU_KIND_PE;
        end
        if (!i_window_open)
        begin
          s_d.st        = PIU_ST_DRAIN;
          s_d.listening = 1'b0;
        end
      end
      PIU_ST_DRAIN:
      begin
        if (f_out_valid && f_out_ready)
        begin
          s_d.done    = 1'b1;
          s_d.content[0] = f_out_data[MW-1:0];
          s_d.origin  = f_out_data[FW-1 -: IDW];
          s_d.kind    = (f_out_data[MW+SW-1 -: SW] != '0) ? PIU_KIND_ACK : PIU_KIND_PE;
        end
        // Wait out a pop's done pulse so two never run back to back
        else if (!f_out_valid && !s_q.done)
        begin
          s_d.st   = PIU_ST_IDLE;
          s_d.done = 1'b1;
        end
      end
      default:
      begin
        s_d.st = PIU_ST_IDLE;
      end
    endcase
    if (i_minor_reset)
    begin
      s_d.st        = PIU_ST_IDLE;
      s_d.listening = 1'b0;
      s_d.done      = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_q    <= '0;
      s_q.st <= PIU_ST_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign lnk.rx_init_pulses   = s_q.init_p;
  assign lnk.rx_echo_pulses   = s_q.echo_p;
  assign lnk.rx_msg_content   = s_q.content;
  assign lnk.rx_msg_strobe    = s_q.strobe;
  assign lnk.inunit_done      = s_q.done;
  assign lnk.inunit_listening = s_q.listening;
  assign lnk.msg_kind_tag     = s_q.kind;
  assign lnk.msg_origin_node  = s_q.origin;
  assign o_syndrome           = s_q.syn;
  assign o_vote_final         = s_q.vfinal;
  assign o_diag_bad           = s_q.dbad;
endmodule

/* hw/piu_pipe.sv */
`timescale 1ns/1ps
module piu_pipe
  import piu_pkg::*;
#(
  parameter int CH = PIU_CHANNELS,
  parameter int MW = PIU_MSG_W
)
(
  input  wire logic          i_sys_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_vote_valid,
  input  wire logic          i_vote_final,
  input  wire logic          i_diag_valid,
  input  wire logic [CH-1:0] i_diag_bad,
  input  wire logic          i_sink_ready,
  output logic               o_done_seen,
  output logic [MW-1:0]      o_last_content,
  piu_link_if.pipe           lnk
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic          vv;
    logic          vf;
    logic          dv;
    logic [CH-1:0] db;
    logic          rdy;
    logic          seen;
    logic [MW-1:0] last;
  } piu_pipe_st_t;
  piu_pipe_st_t s_q;
  piu_pipe_st_t s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.vv   = i_vote_valid;
    s_d.vf   = i_vote_valid && i_vote_final;
    s_d.dv   = i_diag_valid;
    s_d.db   = i_diag_valid ? i_diag_bad : '0;
    s_d.rdy  = i_sink_ready;
    s_d.seen = lnk.inunit_done;
    if (lnk.inunit_done)
    begin
      s_d.last = lnk.rx_msg_content[0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign lnk.vote_result_valid = s_q.vv;
  assign lnk.vote_result_final = s_q.vf;
  assign lnk.diag_result_valid = s_q.dv;
  assign lnk.diag_channel_bad  = s_q.db;
  assign lnk.sink_ready        = s_q.rdy;
  assign o_done_seen           = s_q.seen;
  assign o_last_content        = s_q.last;
endmodule

/* tb/piu_props.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Checks on the link between the two ends
// ------------------------------------------------------------------
module piu_props
  import piu_pkg::*;
#(
  parameter int CH    = 4,
  parameter int NODES = 4
)
(
  input wire logic                i_sys_clk,
  input wire logic                i_rst_n,
  input wire logic                i_minor_reset,
  input wire piu_mode_t           i_rx_mode,
  input wire logic [CH-1:0]       i_link_strobe_in,
  input wire logic [CH-1:0][1:0]  rx_init_pulses,
  input wire logic [CH-1:0][1:0]  rx_echo_pulses,
  input wire logic [CH-1:0]       rx_msg_strobe,
  input wire logic                inunit_done,
  input wire logic                inunit_listening,
  input wire logic [PIU_ID_W-1:0] msg_origin_node,
  input wire logic                sink_ready
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_strobe_one_tick: assert property (
    !i_minor_reset |=> rx_msg_strobe == $past(i_link_strobe_in))
    else $error("output strobe not one tick after input strobe");
  a_strobe_minor_kill: assert property (
    i_minor_reset |=> rx_msg_strobe == '0)
    else $error("strobe survived minor reset");
  a_done_one_cycle: assert property (
    inunit_done |=> !inunit_done)
    else $error("done flag longer than one cycle");
  a_done_needs_sink: assert property (
    !sink_ready && inunit_listening |=> !inunit_done)
    else $error("done flag while sink stalled");
  a_minor_clears_flags: assert property (
    i_minor_reset |=> !inunit_done && !inunit_listening)
    else $error("flags survived minor reset");
  a_origin_in_range: assert property (
    inunit_done && i_rx_mode == PIU_MODE_PE_COMM |->
      msg_origin_node != 0 && msg_origin_node <= NODES)
    else $error("origin node out of range");

  // Retriggering inside a long pulse is not covered here
  for (genvar k = 0; k < CH; k++)
  begin : g_ch
    a_init_short_once: assert property (
      rx_init_pulses[k][0] |=> !rx_init_pulses[k][0])
      else $error("init short pulse too long");
    a_init_long_four: assert property (
      $rose(rx_init_pulses[k][1]) |-> rx_init_pulses[k][1] [*4] ##1 !rx_init_pulses[k][1])
      else $error("init long pulse not four ticks");
    a_echo_short_once: assert property (
      rx_echo_pulses[k][0] |=> !rx_echo_pulses[k][0])
      else $error("echo short pulse too long");
    a_echo_long_four: assert property (
      $rose(rx_echo_pulses[k][1]) |-> rx_echo_pulses[k][1] [*4] ##1 !rx_echo_pulses[k][1])
      else $error("echo long pulse not four ticks");
  end
endmodule

/* tb/protocol_input_unit_interface_test.sv */
`timescale 1ns/1ps
module protocol_input_unit_interface_test;
  import piu_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------
  logic                                   clk, rst_n, minor, win, sink, vv, vf, dv;
  piu_mode_t                              mode;
  logic [PIU_CHANNELS-1:0]                stb, acc_i, acc_e, dbad, diag_q;
  logic [PIU_CHANNELS-1:0][PIU_MSG_W-1:0] cont;
  logic [PIU_CHANNELS-1:0][PIU_SYN_W-1:0] syn, syn_q;
  logic                                   vfin;
  logic                                   seen;
  logic [PIU_MSG_W-1:0]                   last;
  int                                     num_errors, cmp_count, cyc;

  piu_link_if lnk ();
  piu_unit i_piu_unit (.i_sys_clk(clk), .i_rst_n(rst_n), .i_minor_reset(minor),
    .i_rx_mode(mode), .i_window_open(win), .i_link_strobe_in(stb),
    .i_receiver_content(cont), .i_receiver_syndrome(syn), .i_accept_init(acc_i),
    .i_accept_echo(acc_e), .o_syndrome(syn_q), .o_vote_final(vfin), .o_diag_bad(diag_q),
    .lnk(lnk.unit));
  piu_pipe i_piu_pipe (.i_sys_clk(clk), .i_rst_n(rst_n), .i_vote_valid(vv),
    .i_vote_final(vf), .i_diag_valid(dv), .i_diag_bad(dbad), .i_sink_ready(sink),
    .o_done_seen(seen), .o_last_content(last), .lnk(lnk.pipe));
  piu_props #(.CH(PIU_CHANNELS), .NODES(PIU_NODES)) i_piu_props (.i_sys_clk(clk),
    .i_rst_n(rst_n), .i_minor_reset(minor), .i_rx_mode(mode), .i_link_strobe_in(stb),
    .rx_init_pulses(lnk.rx_init_pulses), .rx_echo_pulses(lnk.rx_echo_pulses),
    .rx_msg_strobe(lnk.rx_msg_strobe), .inunit_done(lnk.inunit_done),
    .inunit_listening(lnk.inunit_listening), .msg_origin_node(lnk.msg_origin_node),
    .sink_ready(lnk.sink_ready));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded so a lost done flag cannot hang the run
  task automatic wait_done;
    int n;
    n = 0;
    tick;
    while (lnk.inunit_done !== 1'b1 && n < 20)
    begin
      tick;
      n++;
    end
    chk(lnk.inunit_done, 1'h1);
  endtask
  task automatic results;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_strobe;
    mode = PIU_MODE_STROBED;
    stb = 4'h2;
    cont[1] = 8'h5a;
    syn[1] = 2'h1;
    tick;
    chk(lnk.rx_msg_strobe, 4'h2);
    chk(lnk.rx_msg_content[1], 8'h5a);
    chk(syn_q[1], 2'h1);
    stb = 4'hf;
    cont = 32'h11223344;
    tick;
    stb = 4'h0;
    chk(lnk.rx_msg_strobe, 4'hf);
    chk(lnk.rx_msg_content, 32'h11223344);
    tick;
    chk(lnk.rx_msg_strobe, 4'h0);
    stb = 4'h5;
    minor = 1'b1;
    tick;
    stb = 4'h0;
    minor = 1'b0;
    chk(lnk.rx_msg_strobe, 4'h0);
  endtask
  task automatic t_sync;
    int ns, nl, es, el;
    {ns, nl, es, el} = '0;
    mode = PIU_MODE_SYNC;
    acc_i = 4'h4;
    acc_e = 4'h8;
    for (int i = 0; i < 8; i++)
    begin
      tick;
      {acc_i, acc_e} = '0;
      ns += lnk.rx_init_pulses[2][0];
      nl += lnk.rx_init_pulses[2][1];
      es += lnk.rx_echo_pulses[3][0];
      el += lnk.rx_echo_pulses[3][1];
    end
    chk(ns, 1);
    chk(nl, PIU_LONG_TICKS);
    chk(es, 1);
    chk(el, PIU_LONG_TICKS);
  endtask
  // Ten entries into an eight-deep queue while the sink stalls
  task automatic t_buf;
    int n;
    mode = PIU_MODE_BUFFERED;
    win = 1'b1;
    tick;
    tick;
    chk(lnk.inunit_listening, 1'h1);
    for (int i = 0; i < 10; i++)
    begin
      stb = 4'h1;
      cont[0] = 8'h30 + i[7:0];
      tick;
    end
    stb = 4'h0;
    sink = 1'b1;
    for (int k = 0; k < PIU_FIFO_DEPTH; k++)
    begin
      wait_done;
      chk(lnk.rx_msg_content[0], 32'h30 + k);
      if (k == 3)
      begin
        sink = 1'b0;
        repeat (5) tick;
        sink = 1'b1;
      end
    end
    n = 0;
    repeat (10)
    begin
      tick;
      n += lnk.inunit_done;
    end
    chk(n, 0);
    win = 1'b0;
    repeat (6) tick;
    chk(lnk.inunit_listening, 1'h0);
  endtask
  task automatic t_pe;
    mode = PIU_MODE_PE_COMM;
    win = 1'b1;
    tick;
    stb = 4'h4;
    cont[2] = 8'ha5;
    tick;
    stb = 4'h0;
    wait_done;
    chk(lnk.msg_kind_tag, PIU_KIND_PE);
    chk(lnk.msg_origin_node, 3'h3);
    chk(lnk.rx_msg_content[0], 8'ha5);
    stb = 4'h8;
    syn[3] = 2'h2;
    cont[3] = 8'h6c;
    tick;
    stb = 4'h0;
    chk(seen, 1'h1);
    wait_done;
    chk(lnk.msg_kind_tag, PIU_KIND_ACK);
    chk(lnk.msg_origin_node, 3'h4);
    chk(lnk.rx_msg_content[0], 8'h6c);
    win = 1'b0;
    repeat (6) tick;
    chk(last, 8'h6c);
  endtask
  task automatic t_vote;
    {vv, vf, dv, dbad} = {3'h7, 4'h9};
    tick;
    chk(lnk.vote_result_valid, 1'h1);
    {vv, vf, dv, dbad} = {3'h4, 4'h6};
    tick;
    chk(vfin, 1'h1);
    chk(diag_q, 4'h9);
    tick;
    chk(vfin, 1'h0);
    chk(diag_q, 4'h9);
    vv = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      num_errors++;
      results;
    end
  end
  initial
  begin
    {rst_n, minor, win, sink, vv, vf, dv} = '0;
    {num_errors, cmp_count} = '0;
    mode = PIU_MODE_STROBED;
    {stb, acc_i, acc_e, dbad, cont, syn} = '0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick;
    chk(lnk.rx_msg_strobe, 4'h0);
    chk({lnk.inunit_done, lnk.inunit_listening}, 2'h0);
    t_strobe;
    t_sync;
    t_buf;
    t_pe;
    t_vote;
    results;
  end
endmodule
